// *** evcpwm_top.sv ***
// event counter: 8-bit pwm unit and 8-bit pulse accumulator, modes 0 and 1
//
// Contract
// - pwm unit and accumulator unit each own an 8-bit counter and two compares
// - both mode bits zero selects phase-shift pwm, mode 0
// - mode bits high zero, low one select independent mode 1
// - mode 0 raises pwm_match_irq when pwm_counter equals period compare
// - mode 0 pulse width is period minus skew; skew moves only leading edge
// - mode 0 with skew zero gives width set by period compare alone
// - mode 0 with skew equal period and polarity zero keeps output low
// - mode 0 clears accum_counter on chosen edge or level of second pin
// - mode 0 clocks both counters from the first input selector
// - mode 0 accum match with clear compare clears pwm_counter
// - mode 0 with clear compare zero, external edge clears pwm_counter at once
// - mode 0 raises maskable accum_match_irq on accum event compare match
// - first selector picks pin edges, or gate level inhibiting internal clock
// - first selector pass setting 001 works without using the pin
// - output enabled drives pwm signal with the chosen polarity
// - mode 1 units count and compare fully independently
// - one shared scaled rate; each counter takes bus clock or that rate
// - mode 1 period match clears pwm_counter, raises irq, output goes low
// - mode 1 skew match sets output until period match
// - output off, the pwm unit still counts and compares
// - mode 1 accumulator counts second selector, clears on clear compare
// - mode 1 second selector has rise or fall only, may use bus clock

`include "evcpwm_cfg.svh"

module evcpwm_top
    import evcpwm_pkg::*;
#(
    parameter int CNT_W = 8,
    parameter int ADDR_W = `EVCPWM_ADDR_W
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic clock_in_pin,
    input wire logic second_in_pin,
    output logic event_output,
    output logic event_output_drive,
    output logic pwm_match_irq,
    output logic accum_match_irq
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [`EVCPWM_CTRL_W-1:0] event_control_reg;
    logic [CNT_W-1:0] pwm_counter;
    logic [CNT_W-1:0] pwm_period_compare;
    logic [CNT_W-1:0] pwm_skew_compare;
    logic [CNT_W-1:0] accum_counter;
    logic [CNT_W-1:0] accum_clear_compare;
    logic [CNT_W-1:0] accum_event_compare;
    logic [3:0] first_sel_reg;
    logic [3:0] second_sel_reg;
    logic [`EVCPWM_PRESCALE_W-1:0] prescale_sel;
    logic out_state;
    logic pwm_event_seen;
    logic accum_event_seen;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic clk_pin_meta;
    logic clk_pin_sync;
    logic sec_pin_meta;
    logic sec_pin_sync;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            clk_pin_meta <= 1'b0;
            clk_pin_sync <= 1'b0;
            sec_pin_meta <= 1'b0;
            sec_pin_sync <= 1'b0;
        end else begin
            clk_pin_meta <= clock_in_pin;
            clk_pin_sync <= clk_pin_meta;
            sec_pin_meta <= second_in_pin;
            sec_pin_sync <= sec_pin_meta;
        end
    end

    // ----------------------------------------------------------------
    // mode and control decode
    // ----------------------------------------------------------------
    wire evcpwm_mode_e mode;
    wire mode_phase;
    wire mode_indep;
    wire output_enable_bit;
    wire output_polarity_bit;
    wire irq1_enable;
    wire irq2_enable;
    wire evcpwm_sel_e first_input_selector;
    wire evcpwm_sel_e second_input_selector;

    assign mode = evcpwm_mode_e'({event_control_reg[`EVCPWM_CTRL_MODE_HIGH],
                                  event_control_reg[`EVCPWM_CTRL_MODE_LOW]});
    assign mode_phase = mode == EVCPWM_MODE_PHASE;
    assign mode_indep = mode == EVCPWM_MODE_INDEP;
    assign output_enable_bit = event_control_reg[`EVCPWM_CTRL_OUT_EN];
    assign output_polarity_bit = event_control_reg[`EVCPWM_CTRL_OUT_POL];
    assign irq1_enable = event_control_reg[`EVCPWM_CTRL_IRQ1_EN];
    assign irq2_enable = event_control_reg[`EVCPWM_CTRL_IRQ2_EN];
    assign first_input_selector =
        evcpwm_sel_e'(first_sel_reg[`EVCPWM_SEL_CFG_MSB:`EVCPWM_SEL_CFG_LSB]);
    assign second_input_selector =
        evcpwm_sel_e'(second_sel_reg[`EVCPWM_SEL_CFG_MSB:`EVCPWM_SEL_CFG_LSB]);

    // ----------------------------------------------------------------
    // time base and input selectors
    // ----------------------------------------------------------------
    wire scaled_tick;
    wire first_int_tick;
    wire second_int_tick;
    wire first_tick;
    wire first_restart;
    wire second_tick;
    wire second_restart;

    evcpwm_prescaler #(
        .RATE_W(`EVCPWM_PRESCALE_W)
    ) u_prescaler (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .rate_sel(prescale_sel),
        .scaled_tick(scaled_tick)
    );

    // each selector takes the bus clock or the single shared scaled rate
    assign first_int_tick = first_sel_reg[`EVCPWM_SEL_SCALED] ? scaled_tick : 1'b1;
    assign second_int_tick = second_sel_reg[`EVCPWM_SEL_SCALED] ? scaled_tick : 1'b1;

    evcpwm_input_sel u_first_sel (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin_level(clk_pin_sync),
        .int_tick(first_int_tick),
        .sel_cfg(first_input_selector),
        .allow_both(1'b1),
        .count_tick(first_tick),
        .restart()
    );

    evcpwm_input_sel u_second_sel (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin_level(sec_pin_sync),
        .int_tick(second_int_tick),
        .sel_cfg(second_input_selector),
        .allow_both(1'b0),
        .count_tick(second_tick),
        .restart(second_restart)
    );

    // ----------------------------------------------------------------
    // counting and compare
    // ----------------------------------------------------------------
    wire pwm_tick;
    wire accum_tick;
    wire pwm_at_period;
    wire pwm_at_skew;
    wire accum_at_clear;
    wire accum_at_event;
    wire pwm_period_hit;
    wire pwm_skew_hit;
    wire accum_clear_hit;
    wire accum_event_hit;
    wire ext_restart;
    wire pwm_clear;
    wire accum_clear;
    wire out_set;
    wire out_reset;
    logic [CNT_W-1:0] next_pwm_counter;
    logic [CNT_W-1:0] next_accum_counter;
    logic next_out_state;

    // mode 0 shares the first selector; mode 1 gives each unit its own
    assign pwm_tick = (mode_phase | mode_indep) & first_tick;
    assign accum_tick = mode_phase ? first_tick : (mode_indep & second_tick);
    assign ext_restart = mode_phase & second_restart;

    assign pwm_at_period = pwm_counter == pwm_period_compare;
    assign pwm_at_skew = pwm_counter == pwm_skew_compare;
    assign accum_at_clear = accum_counter == accum_clear_compare;
    assign accum_at_event = accum_counter == accum_event_compare;

    assign pwm_period_hit = pwm_tick & pwm_at_period;
    assign pwm_skew_hit = pwm_tick & pwm_at_skew;
    assign accum_clear_hit = accum_tick & accum_at_clear;
    assign accum_event_hit = accum_tick & accum_at_event;

    // mode 0: the phase-shift match (or the edge itself when phase is zero) restarts pwm
    assign pwm_clear = mode_phase
        ? ((accum_clear_hit & ~ext_restart)
           | (ext_restart & (accum_clear_compare == {CNT_W{1'b0}})))
        : pwm_period_hit;
    assign accum_clear = mode_phase ? ext_restart : accum_clear_hit;

    // period match wins over skew match, so equal values keep the output low
    assign out_reset = pwm_period_hit;
    assign out_set = pwm_skew_hit & ~pwm_period_hit;

    always_comb begin
        next_pwm_counter = pwm_counter;
        if (pwm_clear) begin
            next_pwm_counter = {CNT_W{1'b0}};
        end else if (pwm_tick) begin
            next_pwm_counter = pwm_counter + CNT_W'(1);
        end
    end

    always_comb begin
        next_accum_counter = accum_counter;
        if (accum_clear) begin
            next_accum_counter = {CNT_W{1'b0}};
        end else if (accum_tick) begin
            next_accum_counter = accum_counter + CNT_W'(1);
        end
    end

    always_comb begin
        next_out_state = out_state;
        if (!(mode_phase | mode_indep)) begin
            next_out_state = 1'b0;
        end else if (out_reset) begin
            next_out_state = 1'b0;
        end else if (out_set) begin
            next_out_state = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // register port decode
    // ----------------------------------------------------------------
    wire wr_ctrl;
    wire wr_pwm_cnt;
    wire wr_period;
    wire wr_skew;
    wire wr_acc_cnt;
    wire wr_acc_clr;
    wire wr_acc_evt;
    wire wr_sel1;
    wire wr_sel2;
    wire wr_prescale;
    wire rd_status;
    logic [7:0] rd_mux;

    assign wr_ctrl = reg_wr & (reg_addr == `EVCPWM_OFF_CTRL);
    assign wr_pwm_cnt = reg_wr & (reg_addr == `EVCPWM_OFF_PWM_CNT);
    assign wr_period = reg_wr & (reg_addr == `EVCPWM_OFF_PERIOD);
    assign wr_skew = reg_wr & (reg_addr == `EVCPWM_OFF_SKEW);
    assign wr_acc_cnt = reg_wr & (reg_addr == `EVCPWM_OFF_ACC_CNT);
    assign wr_acc_clr = reg_wr & (reg_addr == `EVCPWM_OFF_ACC_CLR);
    assign wr_acc_evt = reg_wr & (reg_addr == `EVCPWM_OFF_ACC_EVT);
    assign wr_sel1 = reg_wr & (reg_addr == `EVCPWM_OFF_SEL1);
    assign wr_sel2 = reg_wr & (reg_addr == `EVCPWM_OFF_SEL2);
    assign wr_prescale = reg_wr & (reg_addr == `EVCPWM_OFF_PRESCALE);
    assign rd_status = reg_rd & (reg_addr == `EVCPWM_OFF_STATUS);

    always_comb begin
        case (reg_addr)
            `EVCPWM_OFF_CTRL: rd_mux = {2'b00, event_control_reg};
            `EVCPWM_OFF_PWM_CNT: rd_mux = pwm_counter;
            `EVCPWM_OFF_PERIOD: rd_mux = pwm_period_compare;
            `EVCPWM_OFF_SKEW: rd_mux = pwm_skew_compare;
            `EVCPWM_OFF_ACC_CNT: rd_mux = accum_counter;
            `EVCPWM_OFF_ACC_CLR: rd_mux = accum_clear_compare;
            `EVCPWM_OFF_ACC_EVT: rd_mux = accum_event_compare;
            `EVCPWM_OFF_SEL1: rd_mux = {4'h0, first_sel_reg};
            `EVCPWM_OFF_SEL2: rd_mux = {4'h0, second_sel_reg};
            `EVCPWM_OFF_PRESCALE: rd_mux = {5'h00, prescale_sel};
            `EVCPWM_OFF_STATUS: rd_mux = {5'h00, out_state, accum_event_seen, pwm_event_seen};
            default: rd_mux = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            event_control_reg <= `EVCPWM_RST_CTRL;
            pwm_period_compare <= `EVCPWM_RST_CMP;
            pwm_skew_compare <= `EVCPWM_RST_CMP;
            accum_clear_compare <= `EVCPWM_RST_CMP;
            accum_event_compare <= `EVCPWM_RST_CMP;
            first_sel_reg <= `EVCPWM_RST_SEL;
            second_sel_reg <= `EVCPWM_RST_SEL;
            prescale_sel <= `EVCPWM_RST_PRESCALE;
        end else begin
            if (wr_ctrl) event_control_reg <= reg_wdata[`EVCPWM_CTRL_W-1:0];
            if (wr_period) pwm_period_compare <= reg_wdata;
            if (wr_skew) pwm_skew_compare <= reg_wdata;
            if (wr_acc_clr) accum_clear_compare <= reg_wdata;
            if (wr_acc_evt) accum_event_compare <= reg_wdata;
            if (wr_sel1) first_sel_reg <= reg_wdata[3:0];
            if (wr_sel2) second_sel_reg <= reg_wdata[3:0];
            if (wr_prescale) prescale_sel <= reg_wdata[`EVCPWM_PRESCALE_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // counters and output state; a software write beats a count
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pwm_counter <= `EVCPWM_RST_CNT;
            accum_counter <= `EVCPWM_RST_CNT;
            out_state <= 1'b0;
        end else begin
            pwm_counter <= wr_pwm_cnt ? reg_wdata : next_pwm_counter;
            accum_counter <= wr_acc_cnt ? reg_wdata : next_accum_counter;
            out_state <= next_out_state;
        end
    end

    // ----------------------------------------------------------------
    // match indicators: status flags are sticky, cleared by reading status
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pwm_event_seen <= 1'b0;
            accum_event_seen <= 1'b0;
            pwm_match_irq <= 1'b0;
            accum_match_irq <= 1'b0;
        end else begin
            pwm_event_seen <= pwm_period_hit | (pwm_event_seen & ~rd_status);
            accum_event_seen <= accum_event_hit | (accum_event_seen & ~rd_status);
            pwm_match_irq <= pwm_period_hit & irq1_enable;
            accum_match_irq <= accum_event_hit & irq2_enable;
        end
    end

    // ----------------------------------------------------------------
    // output unit and read data
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            event_output <= 1'b0;
            event_output_drive <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            event_output <= output_enable_bit & (next_out_state ^ output_polarity_bit);
            event_output_drive <= output_enable_bit;
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

endmodule

// *** evcpwm_cfg.svh ***
// constants of the event counter: register offsets, field positions, reset values
`ifndef EVCPWM_CFG_SVH
`define EVCPWM_CFG_SVH

// ----------------------------------------------------------------
// register port
// ----------------------------------------------------------------
`define EVCPWM_ADDR_W 4
`define EVCPWM_OFF_CTRL 4'h0
`define EVCPWM_OFF_PWM_CNT 4'h1
`define EVCPWM_OFF_PERIOD 4'h2
`define EVCPWM_OFF_SKEW 4'h3
`define EVCPWM_OFF_ACC_CNT 4'h4
`define EVCPWM_OFF_ACC_CLR 4'h5
`define EVCPWM_OFF_ACC_EVT 4'h6
`define EVCPWM_OFF_SEL1 4'h7
`define EVCPWM_OFF_SEL2 4'h8
`define EVCPWM_OFF_PRESCALE 4'h9
`define EVCPWM_OFF_STATUS 4'hA

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define EVCPWM_CTRL_MODE_LOW 0
`define EVCPWM_CTRL_MODE_HIGH 1
`define EVCPWM_CTRL_OUT_EN 2
`define EVCPWM_CTRL_OUT_POL 3
`define EVCPWM_CTRL_IRQ1_EN 4
`define EVCPWM_CTRL_IRQ2_EN 5
`define EVCPWM_CTRL_W 6

// ----------------------------------------------------------------
// selector register fields
// ----------------------------------------------------------------
`define EVCPWM_SEL_CFG_LSB 0
`define EVCPWM_SEL_CFG_MSB 2
`define EVCPWM_SEL_SCALED 3
`define EVCPWM_PRESCALE_W 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EVCPWM_RST_CTRL 6'h00
`define EVCPWM_RST_CNT 8'h00
`define EVCPWM_RST_CMP 8'hFF
`define EVCPWM_RST_SEL 4'h0
`define EVCPWM_RST_PRESCALE 3'h0

`endif

// *** evcpwm_pkg.sv ***
// types shared by the event counter modules
package evcpwm_pkg;

    // ----------------------------------------------------------------
    // input selector settings
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        EVCPWM_SEL_OFF = 3'b000,
        EVCPWM_SEL_PASS = 3'b001,
        EVCPWM_SEL_GATE_HI = 3'b010,
        EVCPWM_SEL_GATE_LO = 3'b011,
        EVCPWM_SEL_RISE = 3'b100,
        EVCPWM_SEL_FALL = 3'b101,
        EVCPWM_SEL_BOTH = 3'b110,
        EVCPWM_SEL_RSVD = 3'b111
    } evcpwm_sel_e;

    // ----------------------------------------------------------------
    // operating modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        EVCPWM_MODE_PHASE = 2'b00,
        EVCPWM_MODE_INDEP = 2'b01,
        EVCPWM_MODE_PERIOD = 2'b10,
        EVCPWM_MODE_PRESC = 2'b11
    } evcpwm_mode_e;

endpackage

// *** evcpwm_prescaler.sv ***
// shared time base: one scaled bus-clock tick out of eight rates
module evcpwm_prescaler
    import evcpwm_pkg::*;
#(
    parameter int RATE_W = 3
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [RATE_W-1:0] rate_sel,
    output logic scaled_tick
);

    logic [6:0] div_count;
    wire [6:0] div_mask;

    // rate n gives one tick every 2**n bus cycles
    assign div_mask = 7'(8'h7F >> (4'd7 - {1'b0, rate_sel}));
    assign scaled_tick = (div_count & div_mask) == div_mask;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            div_count <= 7'h00;
        end else begin
            div_count <= div_count + 7'h01;
        end
    end

endmodule

// *** evcpwm_input_sel.sv ***
// input selector: edge clocking, gated internal clock or pass, plus restart strobe
module evcpwm_input_sel
    import evcpwm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic pin_level,
    input wire logic int_tick,
    input wire evcpwm_sel_e sel_cfg,
    input wire logic allow_both,
    output logic count_tick,
    output logic restart
);

    logic pin_prev;
    wire pin_rise;
    wire pin_fall;

    assign pin_rise = pin_level & ~pin_prev;
    assign pin_fall = ~pin_level & pin_prev;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_prev <= 1'b0;
        end else begin
            pin_prev <= pin_level;
        end
    end

    // gate levels inhibit counting while active; pin edges clock directly
    always_comb begin
        count_tick = 1'b0;
        restart = 1'b0;
        case (sel_cfg)
            EVCPWM_SEL_PASS: begin
                count_tick = int_tick;
            end
            EVCPWM_SEL_GATE_HI: begin
                count_tick = int_tick & ~pin_level;
                restart = pin_level;
            end
            EVCPWM_SEL_GATE_LO: begin
                count_tick = int_tick & pin_level;
                restart = ~pin_level;
            end
            EVCPWM_SEL_RISE: begin
                count_tick = pin_rise;
                restart = pin_rise;
            end
            EVCPWM_SEL_FALL: begin
                count_tick = pin_fall;
                restart = pin_fall;
            end
            EVCPWM_SEL_BOTH: begin
                count_tick = allow_both & (pin_rise | pin_fall);
                restart = pin_rise | pin_fall;
            end
            default: begin
                count_tick = 1'b0;
                restart = 1'b0;
            end
        endcase
    end

endmodule

// *** evcpwm_top_sva.sv ***
// port assertions of the event counter
module evcpwm_top_chk #(
    parameter int ADDR_W = 4
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic event_output,
    input wire logic event_output_drive,
    input wire logic pwm_match_irq,
    input wire logic accum_match_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ----------
    // sequences
    // ----------
    sequence ctl_wr_s;
        reg_wr && reg_addr == 'h0;
    endsequence
    sequence ctl_rd_s;
        reg_rd && reg_addr == 'h0;
    endsequence
    sequence per_wr_rd_s;
        reg_wr && reg_addr == 'h2 ##1 reg_rd && reg_addr == 'h2;
    endsequence
    // ----------
    // assertions
    // ----------
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_zero_a: assert property (reg_rd && reg_addr > 'hA |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    ctl_back_a: assert property (ctl_wr_s ##1 ctl_rd_s |=>
        reg_rdata == {2'b00, $past(reg_wdata[5:0], 2)}) else $error("control readback wrong");
    ctl_rsvd_a: assert property (ctl_rd_s |=> reg_rdata[7:6] == 2'b00)
        else $error("reserved control bits set");
    period_back_a: assert property (per_wr_rd_s |=> reg_rdata == $past(reg_wdata, 2))
        else $error("period readback wrong");
    drive_follow_a: assert property (ctl_wr_s |-> ##2
        event_output_drive == $past(reg_wdata[2], 2)) else $error("drive not following enable");
    out_off_a: assert property (!event_output_drive [*2] |-> !event_output)
        else $error("output high while disabled");
    irq_mask_a: assert property (reg_wr && reg_addr == 'h0 && !reg_wdata[4]
        |-> ##2 !pwm_match_irq) else $error("masked period irq seen");
    reset_quiet_a: assert property (disable iff (1'b0) sys_rst |=>
        !event_output && !event_output_drive && !pwm_match_irq && !accum_match_irq)
        else $error("outputs active after reset");
endmodule

bind evcpwm_top evcpwm_top_chk #(.ADDR_W(ADDR_W)) u_evcpwm_top_chk (.clk_sys, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .event_output,
    .event_output_drive, .pwm_match_irq, .accum_match_irq);

// *** evcpwm_pins.sv ***
// pin partner: counted square-wave edges on one of the two event pins
module evcpwm_pins (
    input wire logic clk_sys,
    input wire logic go,
    input wire logic pin_sel,
    input wire logic [7:0] n_edges,
    output logic clock_in_pin,
    output logic second_in_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [8:0] left = 9'h000;
    logic [1:0] ph = 2'h0;
    logic lvl = 1'b0;
    // four clocks per half period so the synchronisers see every level
    always @(posedge clk_sys) begin
        if (go) begin
            left <= {n_edges, 1'b0};
            ph <= 2'h0;
        end else if (left != 9'h000) begin
            ph <= ph + 2'h1;
            if (ph == 2'h3) begin
                lvl <= ~lvl;
                left <= left - 9'h001;
            end
        end
    end
    // an unused pin rests low as with a pull-down
    assign clock_in_pin = !pin_sel && lvl;
    assign second_in_pin = pin_sel && lvl;
endmodule

// *** evcpwm_top_tb_top.sv ***
// self-checking bench of the event counter
module evcpwm_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic go = 1'b0;
    logic pin_sel = 1'b0;
    logic [7:0] n_edges = 8'h00;
    logic [7:0] reg_rdata;
    logic clock_in_pin, second_in_pin, event_output, event_output_drive;
    logic pwm_match_irq, accum_match_irq;
    int error_cnt = 0;
    int total_checks = 0;
    int irq2_cnt = 0;
    evcpwm_top u_evcpwm_top (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .clock_in_pin, .second_in_pin, .event_output, .event_output_drive,
        .pwm_match_irq, .accum_match_irq);
    evcpwm_pins u_evcpwm_pins (.clk_sys, .go, .pin_sel, .n_edges, .clock_in_pin,
        .second_in_pin);
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (accum_match_irq === 1'b1) irq2_cnt++;
    end
    // ----------
    // shared tasks
    // ----------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk_sys);
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask
    task automatic pins(input logic s, input logic [7:0] n);
        pin_sel <= s;
        n_edges <= n;
        reg_wr <= 1'b0;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (8 * n + 8) @(posedge clk_sys);
    endtask
    // counts high output cycles and period irqs over one steady window
    task automatic mc(input logic [7:0] c, input int n, input logic [7:0] eh,
        input logic [7:0] eq);
        logic [7:0] h, q;
        wr(4'h0, c);
        reg_wr <= 1'b0;
        repeat (n) @(posedge clk_sys);
        h = 8'h00;
        q = 8'h00;
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            h += {7'h00, event_output};
            q += {7'h00, pwm_match_irq};
        end
        @(posedge clk_sys);
        chk(h, eh);
        chk(q, eq);
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic t_regs;
        rc(4'h0, 8'h00);
        rc(4'h2, 8'hFF);
        rc(4'h1, 8'h00);
        wr(4'h0, 8'h2A);
        rc(4'h0, 8'h2A);
        wr(4'h2, 8'h5A);
        rc(4'h2, 8'h5A);
        wr(4'hC, 8'hFF);
        rc(4'hC, 8'h00);
        wr(4'h0, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_pwm;
        wr(4'h0, 8'h15);
        wr(4'h2, 8'h03);
        wr(4'h3, 8'h01);
        wr(4'h7, 8'h01);
        wr(4'h1, 8'h00);
        mc(8'h15, 8, 8'h04, 8'h02);
        wr(4'h3, 8'h00);
        mc(8'h15, 8, 8'h06, 8'h02);
        mc(8'h1D, 8, 8'h02, 8'h02);
        mc(8'h11, 8, 8'h00, 8'h02);
        mc(8'h05, 8, 8'h06, 8'h00);
        wr(4'h7, 8'h09);
        wr(4'h9, 8'h01);
        mc(8'h15, 8, 8'h06, 8'h01);
        mc(8'h16, 8, 8'h00, 8'h00);
        rc(4'hA, 8'h01);
        rc(4'hA, 8'h00);
        $display("test pwm done");
    endtask
    task automatic t_edges;
        wr(4'h0, 8'h21);
        wr(4'h2, 8'hFF);
        wr(4'h7, 8'h04);
        wr(4'h1, 8'h00);
        pins(1'b0, 8'h05);
        rc(4'h1, 8'h05);
        wr(4'h7, 8'h06);
        wr(4'h1, 8'h00);
        pins(1'b0, 8'h05);
        rc(4'h1, 8'h0A);
        wr(4'h5, 8'h02);
        wr(4'h6, 8'h02);
        wr(4'h8, 8'h04);
        wr(4'h4, 8'h00);
        irq2_cnt = 0;
        pins(1'b1, 8'h04);
        rc(4'h4, 8'h01);
        rc(4'h1, 8'h0A);
        chk(8'(irq2_cnt), 8'h01);
        wr(4'h8, 8'h06);
        wr(4'h4, 8'h00);
        pins(1'b1, 8'h04);
        rc(4'h4, 8'h00);
        $display("test edges done");
    endtask
    task automatic t_mode0;
        logic [7:0] v;
        wr(4'h0, 8'h04);
        wr(4'h5, 8'h00);
        wr(4'h2, 8'h40);
        wr(4'h3, 8'h10);
        wr(4'h7, 8'h01);
        wr(4'h8, 8'h04);
        irq2_cnt = 0;
        mc(8'h34, 256, 8'h30, 8'h01);
        chk(8'(irq2_cnt > 1 && irq2_cnt < 4), 8'h01);
        wr(4'h3, 8'h00);
        mc(8'h14, 256, 8'h40, 8'h01);
        wr(4'h3, 8'h40);
        mc(8'h04, 256, 8'h00, 8'h00);
        wr(4'h1, 8'h80);
        wr(4'h4, 8'h80);
        pins(1'b1, 8'h01);
        rd(4'h1, v);
        chk(8'(v < 8'h20), 8'h01);
        rd(4'h4, v);
        chk(8'(v < 8'h20), 8'h01);
        wr(4'h5, 8'h40);
        reg_wr <= 1'b0;
        repeat (100) @(posedge clk_sys);
        rd(4'h1, v);
        chk(8'(v < 8'h60), 8'h01);
        $display("test mode0 done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        t_regs();
        t_pwm();
        t_edges();
        t_mode0();
        final_report();
    end
    initial begin
        #300000;
        error_cnt++;
        final_report();
    end
endmodule
